// ---- design/fbms_regs.svh ----
`ifndef FBMS_REGS_SVH
`define FBMS_REGS_SVH

// Flash address layout: one bit picks the programming system, the next the bank.
`define FBMS_AW        24
`define FBMS_SYS_BIT   23
`define FBMS_BANK_BIT  22
`define FBMS_NSYS      2

// Register port offsets and fields.
`define FBMS_RA_CTRL   8'h00
`define FBMS_RA_BASE_A 8'h04
`define FBMS_RA_BASE_B 8'h08
`define FBMS_RA_MASK   8'h0c
`define FBMS_RA_STATUS 8'h10
`define FBMS_CTRL_EN   0
`define FBMS_RST_ADDR  24'h00_0000
`define FBMS_RST_WORD  32'h0000_0000

// Hardware property region: nine data-flash blocks.
`define FBMS_PROP_BLOCKS 4'h9
`define FBMS_BLK_TAG   4'h0
`define FBMS_BLK_SW0   4'h1
`define FBMS_BLK_CFG0  4'h3
`define FBMS_BLK_SEC0  4'h5
`define FBMS_BLK_BP0   4'h7
`define FBMS_OFF_ZERO  4'h0
`define FBMS_OFF_OPT12 4'h0
`define FBMS_OFF_OPT13 4'h1

// Flag positions in the property words; an erased (high) flag keeps copy 0.
`define FBMS_VAF_BIT   0
`define FBMS_CVA_BIT   0
`define FBMS_SVA_BIT   1
`define FBMS_BVA_BIT   2
`define FBMS_PROG_HI   15
`define FBMS_PROG_LO   8
`define FBMS_MAP_HI    1
`define FBMS_MAP_LO    0
`define FBMS_MAP_DUAL  2'b10
`define FBMS_BSEL_HI   1
`define FBMS_BSEL_LO   0

`endif

// ---- design/fbms_pkg.sv ----
package fbms_pkg;
    `include "fbms_regs.svh"

    typedef logic [`FBMS_AW-1:0] fbms_addr_type;
    typedef logic [31:0]         fbms_word_type;

    typedef enum logic [4:0] {
        st_tag   = 5'b0_0001,
        st_sw    = 5'b0_0010,
        st_opt12 = 5'b0_0100,
        st_opt13 = 5'b0_1000,
        st_run   = 5'b1_0000
    } fbms_state_type;

    typedef struct packed {
        logic [15:0] zero;
        logic [7:0]  progress;
        logic        switch_valid_flag;
        logic        prot_copy;
        logic        sec_copy;
        logic        cfg_copy;
        logic [1:0]  bank_sel;
        logic        map_dual;
        logic        init_done;
    } fbms_status_type;
endpackage : fbms_pkg

// ---- design/fbms_remap.sv ----
module fbms_remap (
    // Logical read address in.
    input  wire fbms_pkg::fbms_addr_type addr_in,
    // Window setup.
    input  wire logic                    en,
    input  wire fbms_pkg::fbms_addr_type base_a,
    input  wire fbms_pkg::fbms_addr_type base_b,
    input  wire fbms_pkg::fbms_addr_type mask,
    // Translated address out.
    output fbms_pkg::fbms_addr_type      addr_out
);
    import fbms_pkg::*;

    fbms_addr_type hi;
    fbms_addr_type lo;

    // Region A and region B trade places; other addresses pass unchanged.
    always_comb begin
        hi = addr_in & ~mask;
        lo = addr_in & mask;
        if (en && hi == (base_a & ~mask)) begin
            addr_out = (base_b & ~mask) | lo;
        end else if (en && hi == (base_b & ~mask)) begin
            addr_out = (base_a & ~mask) | lo;
        end else begin
            addr_out = addr_in;
        end
    end
endmodule : fbms_remap

// ---- design/fbms_bgo_guard.sv ----
module fbms_bgo_guard (
    // Physical addresses.
    input  wire fbms_pkg::fbms_addr_type phys_addr,
    input  wire fbms_pkg::fbms_addr_type pe_addr,
    // Program or erase in progress.
    input  wire logic                    pe_active,
    // Read would hit the busy bank.
    output logic                         conflict
);
    import fbms_pkg::*;

    always_comb begin
        conflict = pe_active
            && phys_addr[`FBMS_SYS_BIT] == pe_addr[`FBMS_SYS_BIT]
            && phys_addr[`FBMS_BANK_BIT] == pe_addr[`FBMS_BANK_BIT];
    end
endmodule : fbms_bgo_guard

// ---- design/fbms_map_select.sv ----
// Notes on behaviour
// - Two-bit map select field picks single or dual code flash mapping.
// - Single mode: remap unit swaps pre-update and post-update read regions.
// - Translation applies only to processor read accesses using logical addresses.
// - Flash command interface uses physical addresses, never translated.
// - Readability during program or erase is judged on physical addresses.
// - Dual mode: each programming system has its own valid-bank select bit.
// - Fetch from valid banks continues while invalid banks are programmed.
// - After a swap the valid bank appears at the same fixed addresses.
// - Hardware property region holds nine data-flash blocks.
// - Config, security, protection each have two copies; valid copy not updatable.
// - At delivery copy 0 is valid, copy 1 invalid and erased.
// - Switch region has two copies; copy 0 valid at delivery.
// - Switch-valid flag in the tag block picks the valid switch copy.
// - Three selectors in the valid switch copy pick config, security, protection.
// - Switch region progress flags are kept for interrupted-update recovery.
// - New bank assignment takes effect only at reset.
module fbms_map_select (
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // Register port.
    input  wire logic [7:0]              reg_addr,
    input  wire fbms_pkg::fbms_word_type reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output fbms_pkg::fbms_word_type      reg_rdata,
    // Data flash read port for the property region.
    output logic                         df_rd,
    output logic [7:0]                   df_addr,
    input  wire fbms_pkg::fbms_word_type df_rdata,
    // Processor read path.
    input  wire logic                    cpu_rd,
    input  wire fbms_pkg::fbms_addr_type cpu_addr,
    output logic                         flash_rd,
    output fbms_pkg::fbms_addr_type      flash_addr,
    output logic                         cpu_blocked,
    // Flash command interface.
    input  wire logic                    pe_active,
    input  wire fbms_pkg::fbms_addr_type pe_addr,
    output fbms_pkg::fbms_addr_type      flash_cmd_addr,
    input  wire logic                    prop_wr_req,
    input  wire logic [3:0]              prop_wr_blk,
    output logic                         prop_wr_ok,
    // Selected mapping.
    output logic                         map_dual,
    output logic [1:0]                   bank_sel,
    output logic                         cfg_copy,
    output logic                         sec_copy,
    output logic                         prot_copy,
    output logic [7:0]                   progress,
    output logic                         init_done
);
    import fbms_pkg::*;

    fbms_state_type  state_q, state_d;
    logic            wait_q, wait_d;
    logic            vaf_q, vaf_d;
    logic            cfg_q, cfg_d;
    logic            sec_q, sec_d;
    logic            prot_q, prot_d;
    logic [7:0]      prog_q, prog_d;
    logic            dual_q, dual_d;
    logic [1:0]      bsel_q, bsel_d;
    logic            en_q, en_d;
    fbms_addr_type   base_a_q, base_a_d;
    fbms_addr_type   base_b_q, base_b_d;
    fbms_addr_type   mask_q, mask_d;
    fbms_word_type   rdata_q, rdata_d;
    logic            frd_q, frd_d;
    fbms_addr_type   faddr_q, faddr_d;
    logic            blk_q, blk_d;
    fbms_addr_type   remapped;
    fbms_addr_type   phys;
    logic            conflict;
    logic [3:0]      rd_blk;
    logic [3:0]      rd_off;
    fbms_status_type status;
    logic            run;

    assign run = state_q == st_run;

    // Property load sequence: each load state issues one read, then captures it; st_run issues none.
    always_comb begin
        state_d = state_q;
        wait_d  = 1'b0;
        vaf_d   = vaf_q;
        cfg_d   = cfg_q;
        sec_d   = sec_q;
        prot_d  = prot_q;
        prog_d  = prog_q;
        dual_d  = dual_q;
        bsel_d  = bsel_q;
        if (!run) begin
            wait_d = !wait_q;
        end
        unique case (state_q)
            st_tag: begin
                if (wait_q) begin
                    vaf_d   = !df_rdata[`FBMS_VAF_BIT];
                    state_d = st_sw;
                end
            end
            st_sw: begin
                if (wait_q) begin
                    cfg_d   = !df_rdata[`FBMS_CVA_BIT];
                    sec_d   = !df_rdata[`FBMS_SVA_BIT];
                    prot_d  = !df_rdata[`FBMS_BVA_BIT];
                    prog_d  = df_rdata[`FBMS_PROG_HI:`FBMS_PROG_LO];
                    state_d = st_opt12;
                end
            end
            st_opt12: begin
                if (wait_q) begin
                    dual_d  = df_rdata[`FBMS_MAP_HI:`FBMS_MAP_LO] == `FBMS_MAP_DUAL;
                    state_d = st_opt13;
                end
            end
            st_opt13: begin
                if (wait_q) begin
                    bsel_d  = ~df_rdata[`FBMS_BSEL_HI:`FBMS_BSEL_LO];
                    state_d = st_run;
                end
            end
            st_run: begin
                state_d = st_run;
            end
        endcase
    end

    // Block and word of the property read for the current step.
    always_comb begin
        rd_blk = `FBMS_BLK_TAG;
        rd_off = `FBMS_OFF_ZERO;
        unique case (state_q)
            st_tag: begin
                rd_blk = `FBMS_BLK_TAG;
            end
            st_sw: begin
                rd_blk = `FBMS_BLK_SW0 + {3'b000, vaf_q};
            end
            st_opt12: begin
                rd_blk = `FBMS_BLK_CFG0 + {3'b000, cfg_q};
                rd_off = `FBMS_OFF_OPT12;
            end
            st_opt13: begin
                rd_blk = `FBMS_BLK_CFG0 + {3'b000, cfg_q};
                rd_off = `FBMS_OFF_OPT13;
            end
            st_run: begin
                rd_blk = `FBMS_BLK_TAG;
            end
        endcase
    end

    assign df_rd   = !run && !wait_q;
    assign df_addr = {rd_blk, rd_off};

    // Software registers.
    always_comb begin
        en_d     = en_q;
        base_a_d = base_a_q;
        base_b_d = base_b_q;
        mask_d   = mask_q;
        rdata_d  = `FBMS_RST_WORD;
        if (reg_wr) begin
            unique case (reg_addr)
                `FBMS_RA_CTRL:   en_d     = reg_wdata[`FBMS_CTRL_EN];
                `FBMS_RA_BASE_A: base_a_d = reg_wdata[`FBMS_AW-1:0];
                `FBMS_RA_BASE_B: base_b_d = reg_wdata[`FBMS_AW-1:0];
                `FBMS_RA_MASK:   mask_d   = reg_wdata[`FBMS_AW-1:0];
                default:         en_d     = en_q;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `FBMS_RA_CTRL:   rdata_d = {31'h0000_0000, en_q};
                `FBMS_RA_BASE_A: rdata_d = {8'h00, base_a_q};
                `FBMS_RA_BASE_B: rdata_d = {8'h00, base_b_q};
                `FBMS_RA_MASK:   rdata_d = {8'h00, mask_q};
                `FBMS_RA_STATUS: rdata_d = status;
                default:         rdata_d = `FBMS_RST_WORD;
            endcase
        end
    end

    always_comb begin
        status           = '0;
        status.progress  = prog_q;
        status.switch_valid_flag       = vaf_q;
        status.prot_copy = prot_q;
        status.sec_copy  = sec_q;
        status.cfg_copy  = cfg_q;
        status.bank_sel  = bsel_q;
        status.map_dual  = dual_q;
        status.init_done = run;
    end

    // Remap unit serves single mode only.
    fbms_remap u_remap (
        .addr_in  (cpu_addr),
        .en       (en_q && !dual_q),
        .base_a   (base_a_q),
        .base_b   (base_b_q),
        .mask     (mask_q),
        .addr_out (remapped)
    );

    // Logical to physical for processor reads; dual mode flips the bank bit when that system's bank select bit is set.
    always_comb begin
        phys = remapped;
        if (dual_q) begin
            phys = cpu_addr;
            phys[`FBMS_BANK_BIT] = cpu_addr[`FBMS_BANK_BIT]
                ^ bsel_q[cpu_addr[`FBMS_SYS_BIT]];
        end
    end

    fbms_bgo_guard u_guard (
        .phys_addr (phys),
        .pe_addr   (pe_addr),
        .pe_active (pe_active),
        .conflict  (conflict)
    );

    always_comb begin
        frd_d   = cpu_rd && run && !conflict;
        blk_d   = cpu_rd && !(run && !conflict);
        faddr_d = cpu_rd ? phys : faddr_q;
    end

    assign flash_cmd_addr = pe_addr;

    // Valid copies and the active switch copy refuse updates.
    always_comb begin
        prop_wr_ok = prop_wr_req && run && prop_wr_blk < `FBMS_PROP_BLOCKS
            && prop_wr_blk != `FBMS_BLK_SW0 + {3'b000, vaf_q}
            && prop_wr_blk != `FBMS_BLK_CFG0 + {3'b000, cfg_q}
            && prop_wr_blk != `FBMS_BLK_SEC0 + {3'b000, sec_q}
            && prop_wr_blk != `FBMS_BLK_BP0 + {3'b000, prot_q};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= st_tag;
            wait_q   <= 1'b0;
            vaf_q    <= 1'b0;
            cfg_q    <= 1'b0;
            sec_q    <= 1'b0;
            prot_q   <= 1'b0;
            prog_q   <= 8'h00;
            dual_q   <= 1'b0;
            bsel_q   <= 2'b00;
            en_q     <= 1'b0;
            base_a_q <= `FBMS_RST_ADDR;
            base_b_q <= `FBMS_RST_ADDR;
            mask_q   <= `FBMS_RST_ADDR;
            rdata_q  <= `FBMS_RST_WORD;
            frd_q    <= 1'b0;
            faddr_q  <= `FBMS_RST_ADDR;
            blk_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            wait_q   <= wait_d;
            vaf_q    <= vaf_d;
            cfg_q    <= cfg_d;
            sec_q    <= sec_d;
            prot_q   <= prot_d;
            prog_q   <= prog_d;
            dual_q   <= dual_d;
            bsel_q   <= bsel_d;
            en_q     <= en_d;
            base_a_q <= base_a_d;
            base_b_q <= base_b_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            frd_q    <= frd_d;
            faddr_q  <= faddr_d;
            blk_q    <= blk_d;
        end
    end

    assign reg_rdata   = rdata_q;
    assign flash_rd    = frd_q;
    assign flash_addr  = faddr_q;
    assign cpu_blocked = blk_q;
    assign map_dual    = dual_q;
    assign bank_sel    = bsel_q;
    assign cfg_copy    = cfg_q;
    assign sec_copy    = sec_q;
    assign prot_copy   = prot_q;
    assign progress    = prog_q;
    assign init_done   = run;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_issue(fbms_state_type st);
        state_q == st && df_rd;
    endsequence

    sequence s_capture(fbms_state_type st);
        state_q == st && wait_q;
    endsequence

    a_mode_select: assert property (
        s_capture(st_opt12) |=> dual_q == ($past(df_rdata[1:0]) == 2'b10))
        else $error("map mode not taken from select field");

    a_switch_copy: assert property (
        s_issue(st_sw) |-> df_addr[7:4] == (vaf_q ? 4'h2 : 4'h1))
        else $error("switch copy not chosen by valid flag");

    a_cfg_copy: assert property (
        s_issue(st_opt12) |-> df_addr[7:4] == (cfg_q ? 4'h4 : 4'h3))
        else $error("option bytes not read from valid config copy");

    a_load_steps: assert property (
        $fell(sys_rst) |-> !run [*8] ##1 run)
        else $error("property load did not take eight cycles");

    a_held_map: assert property (
        run |=> run && $stable(dual_q) && $stable(bsel_q) && $stable(cfg_q))
        else $error("mapping changed outside reset");

    a_read_only: assert property (
        !cpu_rd |=> !flash_rd)
        else $error("flash read without processor read");

    a_busy_bank: assert property (
        cpu_rd && run && pe_active
        && phys[23:22] == pe_addr[23:22] |=> cpu_blocked && !flash_rd)
        else $error("read of busy physical bank not blocked");

    a_bgo_fetch: assert property (
        cpu_rd && run && pe_active
        && phys[22] != pe_addr[22] |=> flash_rd && flash_addr == $past(phys))
        else $error("fetch from other bank was stalled");

    a_dual_swap: assert property (
        cpu_rd && run && dual_q && bsel_q[cpu_addr[23]] && !conflict
        |=> flash_addr[22] != $past(cpu_addr[22]))
        else $error("swapped bank not presented at fixed address");

    a_single_remap: assert property (
        cpu_rd && run && !dual_q && en_q && !conflict
        && ((cpu_addr & ~mask_q) == (base_a_q & ~mask_q))
        |=> (flash_addr & ~mask_q) == (base_b_q & ~mask_q))
        else $error("region A read not sent to region B");

    a_valid_locked: assert property (
        prop_wr_req && prop_wr_blk == 4'h3 + {3'b000, cfg_q} |-> !prop_wr_ok)
        else $error("valid config copy accepted an update");
endmodule : fbms_map_select

// ---- dv/fbms_df_model.sv ----
module fbms_df_model (
    // Clock.
    input  wire logic               clk,
    // Data flash read port.
    input  wire logic               df_rd,
    input  wire logic [7:0]         df_addr,
    output fbms_pkg::fbms_word_type df_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import fbms_pkg::*;

    fbms_word_type mem [0:255];
    fbms_word_type rdata_q;

    // Every word starts erased, so copy 0 of each area is valid at delivery.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'hFFFF_FFFF;
        end
    end

    // A word answers one cycle after its request; otherwise the bus toggles every cycle.
    always @(posedge clk) begin
        if (df_rd) begin
            rdata_q <= mem[df_addr];
        end else begin
            rdata_q <= ~rdata_q;
        end
    end

    assign df_rdata = rdata_q;
endmodule : fbms_df_model

// ---- dv/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fbms_pkg::*;

    logic          clk;
    logic          sys_rst;
    logic [7:0]    reg_addr;
    fbms_word_type reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    fbms_word_type reg_rdata;
    logic          df_rd;
    logic [7:0]    df_addr;
    fbms_word_type df_rdata;
    logic          cpu_rd;
    fbms_addr_type cpu_addr;
    logic          flash_rd;
    fbms_addr_type flash_addr;
    logic          cpu_blocked;
    logic          pe_active;
    fbms_addr_type pe_addr;
    fbms_addr_type flash_cmd_addr;
    logic          prop_wr_req;
    logic [3:0]    prop_wr_blk;
    logic          prop_wr_ok;
    logic          map_dual;
    logic [1:0]    bank_sel;
    logic          cfg_copy;
    logic          sec_copy;
    logic          prot_copy;
    logic [7:0]    progress;
    logic          init_done;
    fbms_word_type pin_word;
    int            fail_count;
    int            checks;
    int            cycle_count;

    fbms_map_select dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .df_rd(df_rd),
        .df_addr(df_addr), .df_rdata(df_rdata), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .cpu_blocked(cpu_blocked),
        .pe_active(pe_active), .pe_addr(pe_addr), .flash_cmd_addr(flash_cmd_addr),
        .prop_wr_req(prop_wr_req), .prop_wr_blk(prop_wr_blk), .prop_wr_ok(prop_wr_ok),
        .map_dual(map_dual), .bank_sel(bank_sel), .cfg_copy(cfg_copy),
        .sec_copy(sec_copy), .prot_copy(prot_copy), .progress(progress),
        .init_done(init_done)
    );

    // Mapping pins packed like the status word; the switch copy has no pin.
    assign pin_word = {16'h0000, progress, 1'b0, prot_copy, sec_copy, cfg_copy,
                       bank_sel, map_dual, init_done};

    fbms_df_model df_model (
        .clk(clk), .df_rd(df_rd), .df_addr(df_addr), .df_rdata(df_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == 2000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic cmp_word(input fbms_word_type got, input fbms_word_type exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_addr(input fbms_addr_type got, input fbms_addr_type exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected address at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_addr

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic reg_write(input logic [7:0] a, input fbms_word_type d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand for one cycle only, then return to zero.
    task automatic reg_read(input logic [7:0] a, input fbms_word_type exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        cmp_word(reg_rdata, exp);
        @(posedge clk);
        #1;
        cmp_word(reg_rdata, 32'h0000_0000);
    endtask : reg_read

    task automatic cpu_read(input fbms_addr_type a, input logic blk, input fbms_addr_type phys);
        @(posedge clk);
        cpu_rd <= 1'b1;
        cpu_addr <= a;
        @(posedge clk);
        cpu_rd <= 1'b0;
        #1;
        cmp_bit(cpu_blocked, blk);
        cmp_bit(flash_rd, !blk);
        if (!blk) begin
            cmp_addr(flash_addr, phys);
        end
    endtask : cpu_read

    task automatic set_pe(input logic act, input fbms_addr_type a);
        @(posedge clk);
        pe_active <= act;
        pe_addr <= a;
        #1;
        cmp_addr(flash_cmd_addr, a);
    endtask : set_pe

    // Walks blocks 0 to 9; bit b of exp is the grant expected for block b.
    task automatic grant_all(input logic [8:0] exp);
        for (int b = 0; b < 10; b++) begin
            @(posedge clk);
            prop_wr_req <= 1'b1;
            prop_wr_blk <= 4'(b);
            #1;
            cmp_bit(prop_wr_ok, (b < 9) ? exp[b] : 1'b0);
            @(posedge clk);
            prop_wr_req <= 1'b0;
        end
    endtask : grant_all

    // Reset, then check refusals during the load and the exact moment it completes.
    task automatic do_reset;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cpu_rd <= 1'b1;
        cpu_addr <= 24'h00_0010;
        prop_wr_req <= 1'b1;
        prop_wr_blk <= 4'h0;
        #1;
        cmp_bit(prop_wr_ok, 1'b0);
        @(posedge clk);
        cpu_rd <= 1'b0;
        prop_wr_req <= 1'b0;
        #1;
        cmp_bit(cpu_blocked, 1'b1);
        cmp_bit(flash_rd, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        cmp_bit(init_done, 1'b0);
        @(posedge clk);
        #1;
        cmp_bit(init_done, 1'b1);
    endtask : do_reset

    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = 24'h00_0000;
        pe_active = 1'b0;
        pe_addr = 24'h00_0000;
        prop_wr_req = 1'b0;
        prop_wr_blk = 4'h0;
        fail_count = 0;
        checks = 0;
        cycle_count = 0;
        // Delivery state: every selector erased, single mapping, copy 0 valid.
        do_reset();
        reg_read(8'h10, 32'h0000_FF01);
        cmp_word(pin_word, 32'h0000_FF01);
        reg_read(8'h14, 32'h0000_0000);
        grant_all(9'h155);
        reg_write(8'h04, 32'h0000_0000);
        reg_write(8'h08, 32'h0040_0000);
        reg_write(8'h0C, 32'h0000_FFFF);
        reg_read(8'h08, 32'h0040_0000);
        cpu_read(24'h00_0010, 1'b0, 24'h00_0010);
        reg_write(8'h00, 32'h0000_0001);
        cpu_read(24'h00_0123, 1'b0, 24'h40_0123);
        cpu_read(24'h40_0040, 1'b0, 24'h00_0040);
        cpu_read(24'h80_0040, 1'b0, 24'h80_0040);
        set_pe(1'b1, 24'h40_0000);
        cpu_read(24'h00_0010, 1'b1, 24'h00_0000);
        cpu_read(24'h40_0010, 1'b0, 24'h00_0010);
        set_pe(1'b0, 24'h40_0000);
        // Dual mapping, switch copy 1, system 0 swapped, progress 5A.
        df_model.mem[8'h00] = 32'hFFFF_FFFE;
        df_model.mem[8'h20] = 32'hFFFF_5AFA;
        df_model.mem[8'h40] = 32'hFFFF_FFFE;
        df_model.mem[8'h41] = 32'hFFFF_FFFE;
        reg_read(8'h10, 32'h0000_FF01);
        do_reset();
        reg_read(8'h10, 32'h0000_5AD7);
        cmp_word(pin_word, 32'h0000_5A57);
        reg_write(8'h00, 32'h0000_0001);
        reg_write(8'h08, 32'h0040_0000);
        reg_write(8'h0C, 32'h0000_FFFF);
        cpu_read(24'h00_0010, 1'b0, 24'h40_0010);
        cpu_read(24'h80_0010, 1'b0, 24'h80_0010);
        set_pe(1'b1, 24'h00_0000);
        cpu_read(24'h00_0010, 1'b0, 24'h40_0010);
        cpu_read(24'h40_0010, 1'b1, 24'h00_0000);
        set_pe(1'b0, 24'h00_0000);
        grant_all(9'h0CB);
        // Tag word back to erased: the old mapping must return only with reset.
        df_model.mem[8'h00] = 32'hFFFF_FFFF;
        reg_read(8'h10, 32'h0000_5AD7);
        cmp_word(pin_word, 32'h0000_5A57);
        do_reset();
        reg_read(8'h10, 32'h0000_FF01);
        cmp_word(pin_word, 32'h0000_FF01);
        give_verdict();
    end
endmodule : testbench
